// File: verilog/bsd_params.svh
// constants for the bit-test-skip and subroutine-jump decoder
`ifndef BSD_PARAMS_SVH
`define BSD_PARAMS_SVH
`define BSD_OP_SKIP_HI 4'h7
`define BSD_OP_CALL_HI 3'h4
`define BSD_PC_W 13
`define BSD_LIT_W 11
`define BSD_ADDR_W 7
`define BSD_PCL_HI 4
`define BSD_PCL_LO 3
`define BSD_BIT_HI 9
`define BSD_BIT_LO 7
`define BSD_BUBBLE_CLKS 3'h4
`define BSD_NOP_WORD 14'h0000
`define BSD_PC_RST 13'h0000
`endif

// File: verilog/bsd_pkg.sv
// types for the bit-test-skip and subroutine-jump decoder
package bsd_pkg;
    typedef enum logic [1:0] {
        BSD_Q1 = 2'b00,
        BSD_Q2 = 2'b01,
        BSD_Q3 = 2'b10,
        BSD_Q4 = 2'b11
    } bsd_phase_e;
    typedef logic [12:0] bsd_pc_t;
endpackage : bsd_pkg

// File: verilog/bsd_decode.sv
// bit-test-skip and subroutine-jump execution slice of the core
`timescale 1ns/100ps
`include "bsd_params.svh"
module bsd_decode (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // instruction and phase from the core sequencer
    input wire logic [13:0] instrWord,
    input wire logic instrValid,
    input wire bsd_pkg::bsd_phase_e qPhase,
    input wire logic [12:0] pcNow,
    input wire logic [7:0] pcHighLatch,
    // register file read port
    input wire logic [7:0] regReadData,
    output logic [6:0] regReadAddr,
    output logic regReadEn,
    // return stack push
    output logic [12:0] stackPushData,
    output logic stackPush,
    // program counter load
    output logic [12:0] pcLoadValue,
    output logic pcLoad,
    // pipeline control
    output logic execSuppress,
    output logic [13:0] execWord,
    output logic statusWriteEn
);
    import bsd_pkg::*;

    logic isSkip;
    logic isCall;
    logic [2:0] bitSel;
    logic bubble;
    logic skipHit;
    logic [2:0] bubbleRun;

    // skip word 01 11bb bfff ffff, jump word 10 0kkk kkkk kkkk
    // a word shown during a bubble is refused, so both decodes are gated by it
    assign isSkip = instrValid && !bubble && (instrWord[13:10] == `BSD_OP_SKIP_HI);
    assign isCall = instrValid && !bubble && (instrWord[13:11] == `BSD_OP_CALL_HI);
    assign bitSel = instrWord[`BSD_BIT_HI:`BSD_BIT_LO];

    // register read in Q2
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regReadAddr <= 7'h00;
            regReadEn <= 1'b0;
        end else begin
            regReadEn <= isSkip && (qPhase == BSD_Q1);
            regReadAddr <= instrWord[`BSD_ADDR_W-1:0];
        end
    end

    // bit test in Q3; data arrives one edge after the Q2 strobe
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            skipHit <= 1'b0;
        end else if (qPhase == BSD_Q3 && isSkip) begin
            skipHit <= regReadData[bitSel];
        end else if (qPhase == BSD_Q1) begin
            skipHit <= 1'b0;
        end
    end

    // bubble: set at end of Q4 after a taken skip or any jump, lasts one full cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bubble <= 1'b0;
        end else if (qPhase == BSD_Q4) begin
            bubble <= (isSkip && skipHit) || isCall;
        end
    end

    // push in Q2
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stackPush <= 1'b0;
            stackPushData <= `BSD_PC_RST;
        end else begin
            stackPush <= isCall && (qPhase == BSD_Q1);
            if (isCall && qPhase == BSD_Q1) begin
                stackPushData <= pcNow + 13'h0001;
            end
        end
    end

    // program counter write in Q4
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pcLoad <= 1'b0;
            pcLoadValue <= `BSD_PC_RST;
        end else begin
            pcLoad <= isCall && (qPhase == BSD_Q3);
            if (isCall && qPhase == BSD_Q3) begin
                pcLoadValue <= {pcHighLatch[`BSD_PCL_HI:`BSD_PCL_LO], instrWord[`BSD_LIT_W-1:0]};
            end
        end
    end

    // pipeline view: bubble cycle presents a nop to execution
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            execSuppress <= 1'b0;
            execWord <= `BSD_NOP_WORD;
            statusWriteEn <= 1'b0;
        end else begin
            execSuppress <= bubble;
            execWord <= bubble ? `BSD_NOP_WORD : instrWord;
            statusWriteEn <= 1'b0;
        end
    end

    // clocks spent in the current bubble; read only by the checks below
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bubbleRun <= 3'h0;
        end else if (bubble) begin
            bubbleRun <= bubbleRun + 3'h1;
        end else begin
            bubbleRun <= 3'h0;
        end
    end

    // both instructions leave flags alone, so this slice never asserts a status write
    flags_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst) !statusWriteEn)
        else $error("status write raised");

    sequence callQ1_s;
        isCall && qPhase == BSD_Q1;
    endsequence
    sequence pushSeen_s;
        ##1 stackPush && stackPushData == $past(pcNow) + 13'h0001;
    endsequence

    push_value_a: assert property (@(posedge ref_clk) disable iff (sys_rst) callQ1_s |-> pushSeen_s)
        else $error("push value wrong");
    push_phase_a: assert property (@(posedge ref_clk) disable iff (sys_rst) stackPush |-> qPhase == BSD_Q2)
        else $error("push outside Q2");
    pc_phase_a: assert property (@(posedge ref_clk) disable iff (sys_rst) pcLoad |-> qPhase == BSD_Q4)
        else $error("pc load outside Q4");
    pc_value_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (isCall && qPhase == BSD_Q3) |=> pcLoadValue == {$past(pcHighLatch[4:3]), $past(instrWord[10:0])})
        else $error("pc load value wrong");
    call_bubble_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (isCall && qPhase == BSD_Q4) |=> bubble [*4])
        else $error("jump bubble missing");
    skip_bubble_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (isSkip && qPhase == BSD_Q4) |=> bubble == $past(skipHit))
        else $error("skip decision wrong");
    nop_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bubble |=> execSuppress && execWord == `BSD_NOP_WORD)
        else $error("bubble not a nop");
    read_phase_a: assert property (@(posedge ref_clk) disable iff (sys_rst) regReadEn |-> qPhase == BSD_Q2)
        else $error("register read outside Q2");

    // a skip never moves the program counter or the stack by itself
    skip_no_jump_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        isSkip |=> !stackPush && !pcLoad)
        else $error("skip touched pc or stack");
    skip_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (isSkip && qPhase == BSD_Q1) |=> regReadEn && regReadAddr == $past(instrWord[`BSD_ADDR_W-1:0])
        ##1 !regReadEn)
        else $error("register read missing");

    // skip steps: bit seen in Q3, then exactly one instruction cycle of bubble
    sequence skipHitQ3_s;
        isSkip && qPhase == BSD_Q3 && regReadData[instrWord[`BSD_BIT_HI:`BSD_BIT_LO]];
    endsequence
    sequence skipMissQ3_s;
        isSkip && qPhase == BSD_Q3 && !regReadData[instrWord[`BSD_BIT_HI:`BSD_BIT_LO]];
    endsequence
    sequence oneBubble_s;
        ##2 bubble [*4] ##1 !bubble;
    endsequence

    skip_taken_a: assert property (@(posedge ref_clk) disable iff (sys_rst) skipHitQ3_s |-> oneBubble_s)
        else $error("taken skip did not idle one cycle");
    skip_missed_a: assert property (@(posedge ref_clk) disable iff (sys_rst) skipMissQ3_s |-> ##2 !bubble)
        else $error("skip taken on a clear bit");

    // jump steps: push strobe in Q2, pc strobe in Q4, each a single clock
    sequence callSteps_s;
        ##1 stackPush ##1 !stackPush ##1 pcLoad ##1 !pcLoad;
    endsequence

    call_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst) callQ1_s |-> callSteps_s)
        else $error("jump steps out of order");
    call_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (isCall && qPhase == BSD_Q3) |-> oneBubble_s)
        else $error("jump did not idle one cycle");

    // push and pc data outputs stand between strobes, so a late reader still sees the last value
    push_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !stackPush |-> $stable(stackPushData))
        else $error("push data moved without strobe");
    pc_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !pcLoad |-> $stable(pcLoadValue))
        else $error("pc value moved without strobe");

    // the word shown in a bubble cycle is refused: no strobe may follow from it
    bubble_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bubble |=> !regReadEn && !stackPush && !pcLoad)
        else $error("strobe during bubble");
    pass_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !bubble |=> !execSuppress && execWord == $past(instrWord))
        else $error("word not passed through");
    suppress_span_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(execSuppress) |-> execSuppress [*4] ##1 !execSuppress)
        else $error("suppress not one full cycle");
    // the counter catches a bubble that overstays, the fall check one cut short
    bubble_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst) bubbleRun <= `BSD_BUBBLE_CLKS)
        else $error("bubble longer than one cycle");
    bubble_full_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(bubble) |-> bubbleRun == `BSD_BUBBLE_CLKS)
        else $error("bubble shorter than one cycle");
endmodule : bsd_decode

// File: tb/bit_skip_and_subroutine_decode_tb.sv
// self-checking bench for the bit-test-skip and subroutine-jump decoder
`timescale 1ns/100ps
module bit_skip_and_subroutine_decode_tb;
    import bsd_pkg::*;
    logic ref_clk = 0, sys_rst = 1, instrValid = 0, prevSup = 0, bubble = 0;
    logic [13:0] instrWord = 0;
    bsd_phase_e qPhase = BSD_Q1;
    logic [12:0] pcNow = 0;
    logic [7:0] pcHighLatch = 0, regReadData = 0;
    logic [6:0] regReadAddr;
    logic regReadEn, stackPush, pcLoad, execSuppress, statusWriteEn;
    logic [12:0] stackPushData, pcLoadValue;
    logic [13:0] execWord;
    logic [15:0] expQ[$];
    int failures = 0, num_checks = 0;
    bsd_decode DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .instrWord(instrWord), .instrValid(instrValid),
        .qPhase(qPhase), .pcNow(pcNow), .pcHighLatch(pcHighLatch), .regReadData(regReadData),
        .regReadAddr(regReadAddr), .regReadEn(regReadEn), .stackPushData(stackPushData), .stackPush(stackPush),
        .pcLoadValue(pcLoadValue), .pcLoad(pcLoad), .execSuppress(execSuppress), .execWord(execWord),
        .statusWriteEn(statusWriteEn));
    initial forever #2 ref_clk = ~ref_clk;
    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic check(input logic [1:0] k, input logic [12:0] v);
        logic [15:0] e;
        num_checks++;
        e = (expQ.size() > 0) ? expQ.pop_front() : 16'hffff;
        if (e !== {1'b0, k, v}) begin
            failures++;
            $display("wrong value at %0t: event %0d got %h want %h", $time, k, v, e);
        end
    endtask : check
    // the outcome of each word is queued before its four phases run
    task automatic issue(input logic [13:0] w, input logic [7:0] d, input logic [12:0] p, input logic [7:0] l);
        logic nb;
        nb = 0;
        if (!bubble && w[13:10] == 4'h7) begin
            expQ.push_back({3'h0, 6'h00, w[6:0]});
            nb = d[w[9:7]];
        end else if (!bubble && w[13:11] == 3'h4) begin
            expQ.push_back({3'h1, p + 13'h0001});
            expQ.push_back({3'h2, l[4:3], w[10:0]});
            nb = 1;
        end
        if (nb) expQ.push_back({3'h3, 13'h0000});
        for (int ph = 0; ph < 4; ph++) begin
            @(posedge ref_clk);
            qPhase <= bsd_phase_e'(ph);
            instrWord <= w;
            instrValid <= 1;
            regReadData <= d;
            pcNow <= p;
            pcHighLatch <= l;
        end
        bubble = nb;
    endtask : issue
    always @(negedge ref_clk) if (!sys_rst) begin
        if (statusWriteEn) check(2'd3, 13'h1fff);
        if (regReadEn) check(2'd0, {6'h00, regReadAddr});
        if (stackPush) check(2'd1, stackPushData);
        if (pcLoad) check(2'd2, pcLoadValue);
        if (execSuppress && !prevSup) check(2'd3, execWord[12:0] | 13'(execWord[13]));
        prevSup <= execSuppress;
    end
    initial begin
        logic [13:0] w;
        void'($urandom(32'h2593));
        repeat (16) @(posedge ref_clk);
        sys_rst <= 0;
        issue({4'h7, 3'd7, 7'h7f}, 8'h80, 13'h0100, 8'h00);
        issue({3'h4, 11'h7ff}, 8'h00, 13'h0101, 8'hff);
        issue({4'h7, 3'd0, 7'h00}, 8'hfe, 13'h0102, 8'h00);
        issue({3'h4, 11'h7ff}, 8'h00, 13'h1fff, 8'h18);
        issue({3'h4, 11'h000}, 8'h00, 13'h0000, 8'h08);
        $display("directed test done");
        for (int i = 0; i < 300; i++) begin
            w = 14'($urandom);
            case ($urandom % 3)
                0: w[13:10] = 4'h7;
                1: w[13:11] = 3'h4;
                default: w[13:12] = 2'b00;
            endcase
            issue(w, 8'($urandom), 13'($urandom), 8'($urandom));
        end
        $display("random test done");
        for (int i = 0; i < 6; i++) issue(14'h0000, 8'h00, 13'h0000, 8'h00);
        if (expQ.size() != 0) failures++;
        complete_run();
    end
endmodule : bit_skip_and_subroutine_decode_tb
